//--- rtl/vic_pkg.sv
// Constants and types shared by the vectored interrupt controller.
//
// Summary of operation
// - Fifteen hardware sources (bit 13 reserved) and one software break, plus a reset vector.
// - No break or source entry is started while the CPU disable flag (status bit 2) is set.
// - Each hardware source is gated by its enable bit; enables reset to zero.
// - Among pending sources the lowest priority number is served first.
// - An enabled event sets its request flag and wakes a waiting CPU.
// - A pending request with disable clear makes the CPU fetch its vector.
// - Writing zero clears a request flag, writing one leaves it; reads show flags.
// - Entering a source routine through its vector clears that request flag.
// - Vectors are byte pairs, low byte even, edge input 7ff8 down to RTC 7fda.
// - Priorities: SPI tx 1 through RTC 8, then edge 9 through display 16.
// - Break with disable clear pushes state, sets disable, vectors to 7ffe.
// - Reset held low two cycles halts; release starts a six-cycle initialisation.
// - After initialisation: set disable, clear decimal, vector from 7ffc/7ffd.
// - Accepting a hardware source pushes state, sets disable, loads its vector.
// - Edge input and port A transition events set their request flags.
// - Each timer overflow and the base timer overflow set their flags.
// - The display flag is set when scanning of the first buffer line begins.
// - SPI tx flag on empty transmit buffer, rx flag on completed receive.
// - UART rx flag on data ready, tx flag on transmit done; no error request.
// - One USB request merges six sub-events kept inside the USB block.
// - PCM flag is set on timer reload while the FIFO holds under four words.
// - One RTC request merges minute, hour, day and alarm sub-events.
// - With bank feature on, the interrupt bank replaces program bank until return.
package vic_pkg;

  localparam int unsigned VIC_NSRC = 16;
  localparam int unsigned VIC_AW = 12;

  // Register indices; the byte address is four times the index.
  localparam logic [9:0] VIC_IDX_BANK_LO = 10'h030;
  localparam logic [9:0] VIC_IDX_BANK_HI = 10'h031;
  localparam logic [9:0] VIC_IDX_REQ_LO = 10'h03c;
  localparam logic [9:0] VIC_IDX_REQ_HI = 10'h03d;
  localparam logic [9:0] VIC_IDX_ENA_LO = 10'h03e;
  localparam logic [9:0] VIC_IDX_ENA_HI = 10'h03f;
  localparam logic [9:0] VIC_IDX_CTRL = 10'h040;
  localparam logic [9:0] VIC_IDX_STAT = 10'h041;

  localparam logic [15:0] VIC_REQ_RST = 16'h0000;
  localparam logic [15:0] VIC_ENA_RST = 16'h0000;
  localparam logic [15:0] VIC_BANK_RST = 16'h0000;
  localparam logic [15:0] VIC_BANK_MASK = 16'h8fff;
  localparam logic [15:0] VIC_SRC_MASK = 16'hdfff;

  localparam int unsigned VIC_BIT_PCM = 14;
  localparam int unsigned VIC_CTRL_BANK_ON = 0;

  localparam logic [15:0] VIC_VEC_BRK = 16'h7ffe;
  localparam logic [15:0] VIC_VEC_RESET = 16'h7ffc;
  localparam logic [15:0] VIC_VEC_SRC_BASE = 16'h7ff8;

  localparam logic [3:0] VIC_PCM_LOW_WORDS = 4'h4;
  localparam logic [2:0] VIC_INIT_CYC = 3'h6;

  localparam logic [1:0] VIC_RESP_OKAY = 2'h0;
  localparam logic [1:0] VIC_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    VIC_ST_INIT = 2'b00,
    VIC_ST_RESET = 2'b01,
    VIC_ST_IDLE = 2'b10,
    VIC_ST_ENTRY = 2'b11
  } vic_state_e;

endpackage

//--- rtl/vic_arbiter.sv
// Fixed-priority selector over the enabled pending request flags.
`timescale 1ns/1ps
module vic_arbiter
  import vic_pkg::*;
(
  input wire logic [15:0] pend_i, // Enabled pending flags.
  output logic win_valid_o, // Some flag is pending.
  output logic [3:0] win_idx_o // Bit index of the winner.
);

  logic [3:0] bit_idx;

  // Rank 0 maps to bit 8 (SPI transmit), rank 15 to bit 7 (display).
  always_comb begin
    bit_idx = 4'h0;
    win_valid_o = 1'b0;
    win_idx_o = 4'h0;
    for (int r = VIC_NSRC - 1; r >= 0; r--) begin
      bit_idx = 4'(r) ^ 4'h8;
      if (pend_i[bit_idx]) begin
        win_valid_o = 1'b1;
        win_idx_o = bit_idx;
      end
    end
  end

endmodule // vic_arbiter

//--- rtl/vic_top.sv
// Vectored interrupt controller with an AXI4-Lite register slave.
`timescale 1ns/1ps
module vic_top
  import vic_pkg::*;
(
  input wire logic mclk_i, // System clock.
  input wire logic reset_n_i, // Asynchronous reset, active low.
  input wire logic [11:0] s_axi_awaddr_i, // Write address.
  input wire logic s_axi_awvalid_i, // Write address valid.
  output logic s_axi_awready_o, // Write address ready.
  input wire logic [31:0] s_axi_wdata_i, // Write data.
  input wire logic [3:0] s_axi_wstrb_i, // Write byte strobes.
  input wire logic s_axi_wvalid_i, // Write data valid.
  output logic s_axi_wready_o, // Write data ready.
  output logic [1:0] s_axi_bresp_o, // Write response.
  output logic s_axi_bvalid_o, // Write response valid.
  input wire logic s_axi_bready_i, // Write response ready.
  input wire logic [11:0] s_axi_araddr_i, // Read address.
  input wire logic s_axi_arvalid_i, // Read address valid.
  output logic s_axi_arready_o, // Read address ready.
  output logic [31:0] s_axi_rdata_o, // Read data.
  output logic [1:0] s_axi_rresp_o, // Read response.
  output logic s_axi_rvalid_o, // Read data valid.
  input wire logic s_axi_rready_i, // Read data ready.
  input wire logic edge_input_irq_i, // Selected edge seen on edge inputs.
  input wire logic timer0_ovf_i, // Timer 0 overflow.
  input wire logic timer1_ovf_i, // Timer 1 overflow.
  input wire logic timer2_ovf_i, // Timer 2 overflow.
  input wire logic timer3_ovf_i, // Timer 3 overflow.
  input wire logic porta_transition_irq_i, // Port A transition.
  input wire logic base_timer_irq_i, // Base timer overflow.
  input wire logic display_frame_start_i, // First buffer line scan begins.
  input wire logic spi_tx_irq_i, // SPI transmit buffer became empty.
  input wire logic spi_rx_irq_i, // SPI receive complete, buffer full.
  input wire logic uart_tx_irq_i, // UART transmission complete.
  input wire logic uart_rx_irq_i, // UART received data ready.
  input wire logic usb_irq_i, // Merged USB sub-event request.
  input wire logic pcm_reload_i, // PCM timer reload.
  input wire logic [3:0] pcm_fifo_level_i, // Words held in the PCM FIFO.
  input wire logic rtc_irq_i, // Merged RTC sub-event request.
  input wire logic cpu_disable_flag_i, // CPU status register bit 2.
  input wire logic cpu_waiting_i, // CPU is in a wait mode.
  input wire logic brk_exec_i, // Break instruction executed.
  input wire logic entry_ack_i, // CPU took the offered vector.
  input wire logic return_from_irq_i, // Return instruction executed.
  output logic entry_req_o, // Entry offered to the CPU.
  output logic [15:0] entry_vector_o, // Address of the vector low byte.
  output logic entry_push_o, // Entry pushes counter and status.
  output logic set_disable_o, // Pulse: CPU sets disable flag.
  output logic clear_decimal_o, // Pulse: CPU clears decimal mode.
  output logic wake_o, // Pulse: wake the waiting CPU.
  output logic bank_use_irq_o, // Interrupt bank replaces program bank.
  output logic [15:0] irq_bank_o // Interrupt bank register value.
);

  // ----------------------------------------------------------------
  // Source events
  // ----------------------------------------------------------------

  logic [15:0] ev;
  logic pcm_ev;

  assign pcm_ev = pcm_reload_i && (pcm_fifo_level_i < VIC_PCM_LOW_WORDS);

  // Bit 13 is reserved and never requests.
  assign ev = {rtc_irq_i, pcm_ev, 1'b0, usb_irq_i,
               uart_rx_irq_i, uart_tx_irq_i,
               spi_rx_irq_i, spi_tx_irq_i,
               display_frame_start_i,
               base_timer_irq_i, porta_transition_irq_i,
               timer3_ovf_i, timer2_ovf_i, timer1_ovf_i, timer0_ovf_i,
               edge_input_irq_i};

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------

  function automatic logic vic_hit(input logic [11:0] addr, input logic [9:0] idx);
    return (addr[11:2] == idx) && (addr[1:0] == 2'b00);
  endfunction

  function automatic logic vic_mapped(input logic [11:0] addr);
    return vic_hit(addr, VIC_IDX_BANK_LO) || vic_hit(addr, VIC_IDX_BANK_HI) ||
           vic_hit(addr, VIC_IDX_REQ_LO) || vic_hit(addr, VIC_IDX_REQ_HI) ||
           vic_hit(addr, VIC_IDX_ENA_LO) || vic_hit(addr, VIC_IDX_ENA_HI) ||
           vic_hit(addr, VIC_IDX_CTRL) || vic_hit(addr, VIC_IDX_STAT);
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------------------------------

  logic [11:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb_q;
  logic do_wr;
  logic wr_lo;

  assign do_wr = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
  assign wr_lo = do_wr && wstrb_q;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= VIC_RESP_OKAY;
      awaddr_q <= 12'h000;
      wdata_q <= 8'h00;
      wstrb_q <= 1'b0;
    end else begin
      if (s_axi_awready_o && s_axi_awvalid_i) begin
        s_axi_awready_o <= 1'b0;
        awaddr_q <= s_axi_awaddr_i;
      end
      if (s_axi_wready_o && s_axi_wvalid_i) begin
        s_axi_wready_o <= 1'b0;
        wdata_q <= s_axi_wdata_i[7:0];
        wstrb_q <= s_axi_wstrb_i[0];
      end
      if (do_wr) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= vic_mapped(awaddr_q) ? VIC_RESP_OKAY : VIC_RESP_SLVERR;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Enable, bank and control registers
  // ----------------------------------------------------------------

  logic [15:0] ena_q;
  logic [15:0] bank_q;
  logic bank_on_q;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ena_q <= VIC_ENA_RST;
    end else if (wr_lo && vic_hit(awaddr_q, VIC_IDX_ENA_LO)) begin
      ena_q[7:0] <= wdata_q;
    end else if (wr_lo && vic_hit(awaddr_q, VIC_IDX_ENA_HI)) begin
      ena_q[15:8] <= wdata_q & VIC_SRC_MASK[15:8];
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bank_q <= VIC_BANK_RST;
      bank_on_q <= 1'b0;
    end else if (wr_lo) begin
      if (vic_hit(awaddr_q, VIC_IDX_BANK_LO)) begin
        bank_q[7:0] <= wdata_q;
      end
      if (vic_hit(awaddr_q, VIC_IDX_BANK_HI)) begin
        bank_q[15:8] <= wdata_q & VIC_BANK_MASK[15:8];
      end
      if (vic_hit(awaddr_q, VIC_IDX_CTRL)) begin
        bank_on_q <= wdata_q[VIC_CTRL_BANK_ON];
      end
    end
  end

  assign irq_bank_o = bank_q;

  // ----------------------------------------------------------------
  // Request flags and arbitration
  // ----------------------------------------------------------------

  logic [15:0] req_q;
  logic [15:0] sw_clr;
  logic [15:0] ack_clr;
  logic [15:0] pend;
  logic win_valid;
  logic [3:0] win_idx;
  vic_state_e state_q;
  logic ent_src_q;
  logic [3:0] ent_idx_q;

  always_comb begin
    sw_clr = 16'h0000;
    if (wr_lo && vic_hit(awaddr_q, VIC_IDX_REQ_LO)) begin
      sw_clr[7:0] = ~wdata_q;
    end
    if (wr_lo && vic_hit(awaddr_q, VIC_IDX_REQ_HI)) begin
      sw_clr[15:8] = ~wdata_q;
    end
  end

  always_comb begin
    ack_clr = 16'h0000;
    if (state_q == VIC_ST_ENTRY && entry_ack_i && ent_src_q) begin
      ack_clr[ent_idx_q] = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      req_q <= VIC_REQ_RST;
    end else begin
      req_q <= (req_q & ~sw_clr & ~ack_clr) | (ev & VIC_SRC_MASK);
    end
  end

  assign pend = req_q & ena_q;

  vic_arbiter u_arbiter (
    .pend_i(pend),
    .win_valid_o(win_valid),
    .win_idx_o(win_idx)
  );

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= cpu_waiting_i && ((ev & ena_q) != 16'h0000);
    end
  end

  // ----------------------------------------------------------------
  // Entry sequencer
  // ----------------------------------------------------------------

  logic [2:0] init_cnt_q;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= VIC_ST_INIT;
      init_cnt_q <= 3'h0;
      entry_req_o <= 1'b0;
      entry_vector_o <= VIC_VEC_RESET;
      entry_push_o <= 1'b0;
      set_disable_o <= 1'b0;
      clear_decimal_o <= 1'b0;
      ent_src_q <= 1'b0;
      ent_idx_q <= 4'h0;
    end else begin
      set_disable_o <= 1'b0;
      clear_decimal_o <= 1'b0;
      unique case (state_q)
        VIC_ST_INIT: begin
          init_cnt_q <= init_cnt_q + 3'h1;
          if (init_cnt_q == VIC_INIT_CYC - 3'h1) begin
            state_q <= VIC_ST_RESET;
            entry_req_o <= 1'b1;
            entry_vector_o <= VIC_VEC_RESET;
            entry_push_o <= 1'b0;
          end
        end
        VIC_ST_RESET: begin
          if (entry_ack_i) begin
            state_q <= VIC_ST_IDLE;
            entry_req_o <= 1'b0;
            set_disable_o <= 1'b1;
            clear_decimal_o <= 1'b1;
          end
        end
        VIC_ST_IDLE: begin
          if (!cpu_disable_flag_i) begin
            if (brk_exec_i) begin
              state_q <= VIC_ST_ENTRY;
              entry_req_o <= 1'b1;
              entry_vector_o <= VIC_VEC_BRK;
              entry_push_o <= 1'b1;
              ent_src_q <= 1'b0;
            end else if (win_valid) begin
              state_q <= VIC_ST_ENTRY;
              entry_req_o <= 1'b1;
              entry_vector_o <= VIC_VEC_SRC_BASE - {11'h000, win_idx, 1'b0};
              entry_push_o <= 1'b1;
              ent_src_q <= 1'b1;
              ent_idx_q <= win_idx;
            end
          end
        end
        VIC_ST_ENTRY: begin
          if (entry_ack_i) begin
            state_q <= VIC_ST_IDLE;
            entry_req_o <= 1'b0;
            set_disable_o <= 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bank_use_irq_o <= 1'b0;
    end else if (return_from_irq_i) begin
      bank_use_irq_o <= 1'b0;
    end else if (state_q == VIC_ST_ENTRY && entry_ack_i && bank_on_q) begin
      bank_use_irq_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------

  logic [7:0] rd_val;

  always_comb begin
    rd_val = 8'h00;
    if (vic_hit(s_axi_araddr_i, VIC_IDX_REQ_LO)) rd_val = req_q[7:0];
    if (vic_hit(s_axi_araddr_i, VIC_IDX_REQ_HI)) rd_val = req_q[15:8];
    if (vic_hit(s_axi_araddr_i, VIC_IDX_ENA_LO)) rd_val = ena_q[7:0];
    if (vic_hit(s_axi_araddr_i, VIC_IDX_ENA_HI)) rd_val = ena_q[15:8];
    if (vic_hit(s_axi_araddr_i, VIC_IDX_BANK_LO)) rd_val = bank_q[7:0];
    if (vic_hit(s_axi_araddr_i, VIC_IDX_BANK_HI)) rd_val = bank_q[15:8];
    if (vic_hit(s_axi_araddr_i, VIC_IDX_CTRL)) rd_val = {7'h00, bank_on_q};
    if (vic_hit(s_axi_araddr_i, VIC_IDX_STAT)) begin
      rd_val = {1'b0, bank_use_irq_o, entry_req_o, win_valid, win_idx};
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= VIC_RESP_OKAY;
    end else if (s_axi_arready_o && s_axi_arvalid_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= {24'h000000, rd_val};
      s_axi_rresp_o <= vic_mapped(s_axi_araddr_i) ? VIC_RESP_OKAY : VIC_RESP_SLVERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  logic [7:0] exp_lo;

  assign exp_lo = req_q[7:0] & wdata_q;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  a_disable_blocks: assert property (
    state_q == VIC_ST_IDLE && cpu_disable_flag_i |=> !entry_req_o)
    else $error("entry offered while disable flag set");

  a_enable_gates: assert property (
    state_q == VIC_ST_IDLE && !brk_exec_i && pend == 16'h0000 |=> !entry_req_o)
    else $error("entry offered with no enabled request");

  a_spi_tx_first: assert property (
    pend[8] |-> win_valid && win_idx == 4'h8)
    else $error("SPI transmit not chosen first");

  a_edge_over_timer: assert property (
    pend[15:8] == 8'h00 && pend[0] |-> win_idx == 4'h0)
    else $error("edge input not chosen over timers");

  a_source_vector: assert property (
    state_q == VIC_ST_IDLE && !cpu_disable_flag_i && !brk_exec_i && win_valid
    |=> entry_req_o && entry_push_o
        && entry_vector_o == VIC_VEC_SRC_BASE - {11'h000, $past(win_idx), 1'b0})
    else $error("wrong source vector");

  a_brk_vector: assert property (
    state_q == VIC_ST_IDLE && !cpu_disable_flag_i && brk_exec_i
    |=> entry_req_o && entry_push_o && entry_vector_o == VIC_VEC_BRK)
    else $error("wrong break vector");

  a_reset_entry: assert property (
    state_q == VIC_ST_INIT && init_cnt_q == 3'h5
    |=> entry_req_o && !entry_push_o && entry_vector_o == VIC_VEC_RESET)
    else $error("reset entry not after six cycles");

  a_entry_taken: assert property (
    state_q != VIC_ST_IDLE && state_q != VIC_ST_INIT && entry_ack_i
    |=> set_disable_o && !entry_req_o ##1 !set_disable_o)
    else $error("entry acknowledge mishandled");

  a_ack_clears: assert property (
    state_q == VIC_ST_ENTRY && entry_ack_i && ent_src_q && !ev[ent_idx_q]
    |=> !req_q[$past(ent_idx_q)])
    else $error("request flag survives entry");

  a_sw_clear_lo: assert property (
    wr_lo && vic_hit(awaddr_q, VIC_IDX_REQ_LO) && ev == 16'h0000 && ack_clr == 16'h0000
    |=> req_q[7:0] == $past(exp_lo))
    else $error("request write did not clear as written");

  a_set_wins: assert property (
    ev != 16'h0000 |=> (req_q & $past(ev)) == ($past(ev) & VIC_SRC_MASK))
    else $error("event lost against a clear");

  a_wake_cpu: assert property (
    cpu_waiting_i && (ev & ena_q) != 16'h0000 |=> wake_o)
    else $error("waiting CPU not woken");

  a_bank_held: assert property (
    bank_use_irq_o && !return_from_irq_i |=> bank_use_irq_o)
    else $error("interrupt bank dropped before return");

endmodule // vic_top

//--- tb/vic_cpu_model.sv
// Behavioural CPU core that takes offered entries and keeps the disable flag.
`timescale 1ns/1ps
module vic_cpu_model (
  input wire logic clk_i, // System clock.
  input wire logic rst_n_i, // Reset, active low.
  input wire logic req_i, // Entry offered.
  input wire logic [15:0] vec_i, // Offered vector.
  input wire logic push_i, // Entry pushes state.
  input wire logic set_dis_i, // Set disable flag.
  input wire logic ret_i, // Return executed.
  input wire logic [3:0] delay_i, // Cycles before taking an entry.
  output logic ack_o, // Entry taken.
  output logic dis_o, // Disable flag.
  output logic [15:0] vec_o, // Last vector taken.
  output logic push_o, // Push flag of last entry.
  output logic [7:0] cnt_o // Entries taken.
);
  logic [3:0] wait_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o <= 1'b0;
      dis_o <= 1'b1;
      vec_o <= 16'h0000;
      push_o <= 1'b0;
      cnt_o <= 8'h00;
      wait_q <= 4'h0;
    end else begin
      ack_o <= 1'b0;
      if (ret_i) dis_o <= 1'b0;
      if (set_dis_i) dis_o <= 1'b1;
      if (req_i && !ack_o) begin
        wait_q <= wait_q + 4'h1;
        if (wait_q == delay_i) begin
          ack_o <= 1'b1;
          dis_o <= 1'b1;
          vec_o <= vec_i;
          push_o <= push_i;
          cnt_o <= cnt_o + 8'h01;
          wait_q <= 4'h0;
        end
      end
    end
  end
endmodule // vic_cpu_model

//--- tb/vectored_interrupt_controller_test.sv
// Self-checking bench for the vectored interrupt controller.
`timescale 1ns/1ps
module vectored_interrupt_controller_test;
  import vic_pkg::*;
  logic clk, rst_n, awv, wv, bready, arv, rready, brk, ret, waiting;
  logic awrdy, wrdy, bvalid, arrdy, rvalid, req, push, sdis, cdec, wake, busy, ack, dis, mpush;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, lvl, dly;
  logic [1:0] bresp, rresp;
  logic [15:0] src, vec, bank, mvec;
  logic [7:0] cnt;
  int error_cnt, checks, ncd, nwk, b;
  initial clk = 1'b0;
  always #20 clk = ~clk;
  always @(negedge clk) begin
    if (cdec === 1'b1) ncd++;
    if (wake === 1'b1) nwk++;
  end
  vic_top u_vic_top (.mclk_i(clk), .reset_n_i(rst_n), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awrdy), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arrdy),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .edge_input_irq_i(src[0]), .timer0_ovf_i(src[1]),
    .timer1_ovf_i(src[2]), .timer2_ovf_i(src[3]), .timer3_ovf_i(src[4]),
    .porta_transition_irq_i(src[5]), .base_timer_irq_i(src[6]),
    .display_frame_start_i(src[7]), .spi_tx_irq_i(src[8]), .spi_rx_irq_i(src[9]),
    .uart_tx_irq_i(src[10]), .uart_rx_irq_i(src[11]), .usb_irq_i(src[12]),
    .pcm_reload_i(src[14]), .pcm_fifo_level_i(lvl), .rtc_irq_i(src[15]),
    .cpu_disable_flag_i(dis), .cpu_waiting_i(waiting), .brk_exec_i(brk),
    .entry_ack_i(ack), .return_from_irq_i(ret), .entry_req_o(req),
    .entry_vector_o(vec), .entry_push_o(push), .set_disable_o(sdis),
    .clear_decimal_o(cdec), .wake_o(wake), .bank_use_irq_o(busy), .irq_bank_o(bank));
  vic_cpu_model u_vic_cpu_model (.clk_i(clk), .rst_n_i(rst_n), .req_i(req), .vec_i(vec),
    .push_i(push), .set_dis_i(sdis), .ret_i(ret), .delay_i(dly), .ack_o(ack), .dis_o(dis),
    .vec_o(mvec), .push_o(mpush), .cnt_o(cnt));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("errors=%0d checks=%0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic timeout;
    cmp(32'h0, 32'h1);
    complete_run;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      if (awrdy) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      if (bvalid) begin
        cmp(32'(bresp), 32'(er));
        return;
      end
    end
    timeout;
  endtask
  task automatic rd(input logic [9:0] idx, input logic [31:0] exp, input logic [1:0] er);
    araddr <= {idx, 2'b00};
    arv <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      if (arrdy) arv <= 1'b0;
      if (rvalid) begin
        cmp(rdata, exp);
        cmp(32'(rresp), 32'(er));
        return;
      end
    end
    timeout;
  endtask
  task automatic wait_entry(input logic [7:0] n);
    for (int i = 0; i < 60; i++) begin
      @(posedge clk);
      if (cnt === n) return;
    end
    timeout;
  endtask
  task automatic pulse(input logic [15:0] m, input logic bk, input logic rt);
    src <= m;
    brk <= bk;
    ret <= rt;
    @(posedge clk);
    src <= 16'h0000;
    brk <= 1'b0;
    ret <= 1'b0;
    @(posedge clk);
  endtask
  initial begin
    {awv, wv, arv, brk, ret, waiting, rst_n} = 7'h00;
    {bready, rready} = 2'b11;
    {awaddr, araddr, wdata, src} = 72'h0;
    {wstrb, lvl, dly} = 12'h130;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    wait_entry(8'h01);
    @(posedge clk);
    cmp(32'(mvec), 32'(VIC_VEC_RESET));
    cmp(32'(mpush), 32'h0);
    cmp(32'(ncd), 32'h1);
    for (int i = 0; i < 4; i++) rd(VIC_IDX_REQ_LO + 10'(i), 32'h0, VIC_RESP_OKAY);
    rd(10'h3ff, 32'h0, VIC_RESP_SLVERR);
    wr(10'h3ff, 8'hff, VIC_RESP_SLVERR);
    pulse(16'h0002, 1'b0, 1'b0);
    rd(VIC_IDX_REQ_LO, 32'h02, VIC_RESP_OKAY);
    wr(VIC_IDX_REQ_LO, 8'hff, VIC_RESP_OKAY);
    rd(VIC_IDX_REQ_LO, 32'h02, VIC_RESP_OKAY);
    wr(VIC_IDX_REQ_LO, 8'hfd, VIC_RESP_OKAY);
    rd(VIC_IDX_REQ_LO, 32'h00, VIC_RESP_OKAY);
    lvl <= 4'h4;
    pulse(16'h4000, 1'b0, 1'b0);
    lvl <= 4'h3;
    rd(VIC_IDX_REQ_HI, 32'h00, VIC_RESP_OKAY);
    waiting <= 1'b1;
    wr(VIC_IDX_ENA_LO, 8'h01, VIC_RESP_OKAY);
    pulse(16'h0002, 1'b0, 1'b0);
    pulse(16'h0001, 1'b0, 1'b0);
    waiting <= 1'b0;
    cmp(32'(nwk), 32'h1);
    wr(VIC_IDX_ENA_LO, 8'hff, VIC_RESP_OKAY);
    wr(VIC_IDX_ENA_HI, 8'hff, VIC_RESP_OKAY);
    rd(VIC_IDX_ENA_HI, 32'hdf, VIC_RESP_OKAY);
    wr(VIC_IDX_CTRL, 8'h01, VIC_RESP_OKAY);
    rd(VIC_IDX_CTRL, 32'h01, VIC_RESP_OKAY);
    wr(VIC_IDX_BANK_LO, 8'h5a, VIC_RESP_OKAY);
    wr(VIC_IDX_BANK_HI, 8'hff, VIC_RESP_OKAY);
    rd(VIC_IDX_BANK_HI, 32'h8f, VIC_RESP_OKAY);
    pulse(16'hffff, 1'b0, 1'b0);
    rd(VIC_IDX_REQ_LO, 32'hff, VIC_RESP_OKAY);
    rd(VIC_IDX_REQ_HI, 32'hdf, VIC_RESP_OKAY);
    rd(VIC_IDX_STAT, 32'h18, VIC_RESP_OKAY);
    for (int k = 0; k < 16; k++) begin
      b = (k < 8) ? k + 8 : k - 8;
      if (b != 13) begin
        pulse(16'h0000, 1'b0, 1'b1);
        wait_entry(cnt + 8'h01);
        @(posedge clk);
        cmp(32'(mvec), 32'(VIC_VEC_SRC_BASE - 16'(2 * b)));
        cmp(32'(busy), 32'h1);
      end
    end
    rd(VIC_IDX_REQ_LO, 32'h00, VIC_RESP_OKAY);
    rd(VIC_IDX_REQ_HI, 32'h00, VIC_RESP_OKAY);
    cmp(32'(bank), 32'h8f5a);
    pulse(16'h0000, 1'b0, 1'b1);
    cmp(32'(busy), 32'h0);
    pulse(16'h0000, 1'b1, 1'b0);
    wait_entry(8'h11);
    cmp(32'(mvec), 32'(VIC_VEC_BRK));
    cmp(32'(mpush), 32'h1);
    dly <= 4'h5;
    pulse(16'h0004, 1'b1, 1'b0);
    repeat (10) @(posedge clk);
    cmp(32'(cnt), 32'h11);
    pulse(16'h0000, 1'b0, 1'b1);
    wait_entry(8'h12);
    cmp(32'(mvec), 32'h7ff4);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wait_entry(8'h01);
    @(posedge clk);
    cmp(32'(ncd), 32'h2);
    rd(VIC_IDX_ENA_LO, 32'h0, VIC_RESP_OKAY);
    complete_run;
  end
endmodule // vectored_interrupt_controller_test
